// *** common/ccc_consts.vh ***
// Register map, field positions, codes and reset values of the configuration block
`ifndef CCC_CONSTS_VH
`define CCC_CONSTS_VH

`define CCC_ADDR_W 8
`define CCC_OFS_STATUS 8'h00
`define CCC_OFS_STARTUP 8'h04
`define CCC_OFS_PRTC 8'h08
`define CCC_OFS_TU1 8'h0c
`define CCC_OFS_TU2 8'h10
`define CCC_OFS_TU4 8'h14
`define CCC_OFS_TU7 8'h18
`define CCC_OFS_TU8 8'h1c
`define CCC_OFS_LAYOUT 8'h20
`define CCC_OFS_HDC 8'h24
`define CCC_OFS_RAMADDR 8'h28
`define CCC_OFS_RAMDATA 8'h2c
`define CCC_OFS_LSTAT 8'h30
`define CCC_OFS_CSTAT 8'h34

`define CCC_RESP_OKAY 2'h0
`define CCC_RESP_SLVERR 2'h2

`define CCC_PST_DEFAULT 6'h00
`define CCC_PST_SETUP 6'h0f
`define CCC_PST_READY 6'h01
`define CCC_PST_RUN 6'h02

`define CCC_CMD_NONE 4'h0
`define CCC_CMD_SETUP 4'h1
`define CCC_CMD_READY 4'h2
`define CCC_CMD_RUN 4'h3
`define CCC_CMD_ALLOW_CS 4'h9

`define CCC_CMD_MSB 3
`define CCC_CMD_LSB 0
`define CCC_STARTUP_EN_BIT 8
`define CCC_SYNC_EN_BIT 9
`define CCC_CSI_BIT 8

`define CCC_FDB_MSB 7
`define CCC_FDB_LSB 0
`define CCC_FFB_MSB 15
`define CCC_FFB_LSB 8
`define CCC_LCB_MSB 22
`define CCC_LCB_LSB 16
`define CCC_SPLIT_BIT 24
`define CCC_LOCK_HDR_BIT 26
`define CCC_LOCK_TX_BIT 27
`define CCC_BUF_NONE 8'h80

`define CCC_MT_DIV_MSB 15
`define CCC_MT_W 14
`define CCC_SLOT_LEN_MSB 9
`define CCC_SLOT_NUM_MSB 25
`define CCC_SLOT_NUM_LSB 16
`define CCC_MINI_LEN_MSB 5

`define CCC_SEG_STATIC 2'h0
`define CCC_SEG_DYNAMIC 2'h1
`define CCC_SEG_SYMBOL 2'h2
`define CCC_SEG_NIT 2'h3

`define CCC_RAM_AW 11
`define CCC_RAM_WORDS 2048
`define CCC_HDR_SHIFT 2

`define CCC_RST_ZERO 32'h0000_0000
`define CCC_RST_LAYOUT 32'h0000_8080
`define CCC_RST_TU1 32'h0000_0001

`endif

// *** design/ccc_msg_ram.v ***
// Message RAM of 8KB, one write port and an asynchronous read port
`timescale 1ns/10ps
`default_nettype none
`include "ccc_consts.vh"

module ccc_msg_ram (
    input wire aclk,
    input wire we,
    input wire [`CCC_RAM_AW-1:0] addr,
    input wire [31:0] wdata,
    output wire [31:0] rdata
);

reg [31:0] mem [0:`CCC_RAM_WORDS-1];

always @(posedge aclk) begin
    if (we) begin
        mem[addr] <= wdata;
    end
end

assign rdata = mem[addr];

endmodule
`default_nettype wire

// *** design/ccc_axil_slave.v ***
// AXI4-Lite handshake engine: one write and one read in flight
`timescale 1ns/10ps
`default_nettype none
`include "ccc_consts.vh"

module ccc_axil_slave (
    input wire aclk,
    input wire aresetn,
    input wire [`CCC_ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`CCC_ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output wire wr_en,
    output reg [`CCC_ADDR_W-1:0] wr_addr,
    output reg [31:0] wr_data,
    output reg [3:0] wr_strb,
    input wire wr_hit,
    output wire rd_en,
    output reg [`CCC_ADDR_W-1:0] rd_addr,
    input wire rd_hit
);

reg aw_full_reg;
reg w_full_reg;
reg rd_pend_reg;
reg aw_full_next;
reg w_full_next;
reg bvalid_next;
reg rd_pend_next;
reg rvalid_next;

wire aw_take = s_axi_awvalid & s_axi_awready;
wire w_take = s_axi_wvalid & s_axi_wready;
wire ar_take = s_axi_arvalid & s_axi_arready;

// Register access once both halves of a write are held
assign wr_en = aw_full_reg & w_full_reg & ~s_axi_bvalid;
assign rd_en = rd_pend_reg;

always @* begin
    aw_full_next = wr_en ? 1'b0 : (aw_full_reg | aw_take);
    w_full_next = wr_en ? 1'b0 : (w_full_reg | w_take);
    bvalid_next = wr_en | (s_axi_bvalid & ~s_axi_bready);
    rd_pend_next = ar_take;
    rvalid_next = rd_pend_reg | (s_axi_rvalid & ~s_axi_rready);
end

always @(posedge aclk) begin
    if (!aresetn) begin
        aw_full_reg <= 1'b0;
        w_full_reg <= 1'b0;
        rd_pend_reg <= 1'b0;
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_arready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_bresp <= `CCC_RESP_OKAY;
        s_axi_rresp <= `CCC_RESP_OKAY;
        wr_addr <= {`CCC_ADDR_W{1'b0}};
        wr_data <= `CCC_RST_ZERO;
        wr_strb <= 4'h0;
        rd_addr <= {`CCC_ADDR_W{1'b0}};
    end else begin
        aw_full_reg <= aw_full_next;
        w_full_reg <= w_full_next;
        rd_pend_reg <= rd_pend_next;
        s_axi_bvalid <= bvalid_next;
        s_axi_rvalid <= rvalid_next;
        s_axi_awready <= ~aw_full_next & ~bvalid_next;
        s_axi_wready <= ~w_full_next & ~bvalid_next;
        s_axi_arready <= ~rd_pend_next & ~rvalid_next;
        if (aw_take) begin
            wr_addr <= s_axi_awaddr;
        end
        if (w_take) begin
            wr_data <= s_axi_wdata;
            wr_strb <= s_axi_wstrb;
        end
        if (ar_take) begin
            rd_addr <= s_axi_araddr;
        end
        if (wr_en) begin
            s_axi_bresp <= wr_hit ? `CCC_RESP_OKAY : `CCC_RESP_SLVERR;
        end
        if (rd_pend_reg) begin
            s_axi_rresp <= rd_hit ? `CCC_RESP_OKAY : `CCC_RESP_SLVERR;
        end
    end
end

endmodule
`default_nettype wire

// *** design/ccc_config_top.v ***
// Configuration, node role, cycle layout and message RAM partition of the bus controller
//
// Decided for this implementation: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
`include "ccc_consts.vh"

// Function
// - Cycle is built from static segment, dynamic segment and idle time start.
// - No symbol window register; window spans dynamic end to idle time start.
// - Cycle timing registers take writes only in setup state 001111.
// - Protocol timing and timing unit 1 and 2 writes only in setup.
// - Buffer layout and header/data config writes only in setup.
// - Startup node and sync node roles follow their enable bits.
// - Startup and sync frames come only from message buffers 0 and 1.
// - Split mode 0 uses buffer 0 only; split mode 1 adds buffer 1.
// - Coldstart inhibit set on entering ready, blocks coldstart, cleared by 1001.
// - 8KB message RAM holds 0 to 128 message buffers; here buffer 0 is always configured, so 1 to 128.
// - Lock field restricts header writes and gates static segment transmission.
// - FIFO spans first FIFO index through last configured index.
// - First dynamic index of 128 or more means no dynamic buffers.
// - First FIFO index of 128 or more means no FIFO.
// - Partition settings are never checked; bad layouts give no error.
// - Hardware reset enters default config, state field 000000.
// - Command 0001 moves the controller to setup state.
// - Each buffer has a 16-byte header then a data area.
module ccc_config_top (
    input wire aclk,
    input wire aresetn,
    input wire [`CCC_ADDR_W-1:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,
    input wire [`CCC_ADDR_W-1:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,
    output reg [5:0] protocol_state,
    output reg coldstart_inhibit,
    output reg startup_node_active,
    output reg sync_node_active,
    output reg coldstart_permitted,
    output reg [1:0] key_buffer_mask,
    output reg static_tx_enable,
    output reg [1:0] cycle_segment,
    output reg symbol_window,
    output reg cycle_start
);

wire wr_en;
wire [`CCC_ADDR_W-1:0] wr_addr;
wire [31:0] wr_data;
wire [3:0] wr_strb;
wire rd_en;
wire [`CCC_ADDR_W-1:0] rd_addr;
reg wr_hit;
reg rd_hit;

ccc_axil_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_hit(wr_hit),
    .rd_en(rd_en),
    .rd_addr(rd_addr),
    .rd_hit(rd_hit)
);

// Software-visible state
reg [5:0] pstate_reg;
reg csi_reg;
reg [31:0] startup_ctl_reg;
reg [31:0] prtc_reg;
reg [31:0] tu1_reg;
reg [31:0] tu2_reg;
reg [31:0] tu4_reg;
reg [31:0] tu7_reg;
reg [31:0] tu8_reg;
reg [31:0] layout_reg;
reg [31:0] hdc_reg;
reg [`CCC_RAM_AW-1:0] ram_addr_reg;

// Byte-lane mask from write strobes
wire [31:0] wmask;
genvar gi;
generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_lane
        assign wmask[8*gi+7:8*gi] = {8{wr_strb[gi]}};
    end
endgenerate

function [31:0] merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [31:0] mask;
    begin
        merge = (old_val & ~mask) | (new_val & mask);
    end
endfunction

wire in_setup = (pstate_reg == `CCC_PST_SETUP);
wire wr_cmd = wr_en && (wr_addr == `CCC_OFS_STARTUP) && wr_strb[0];
wire [3:0] cmd = wr_data[`CCC_CMD_MSB:`CCC_CMD_LSB];
wire cfg_wr = wr_en & in_setup;

// Partition fields
wire [7:0] fdb = layout_reg[`CCC_FDB_MSB:`CCC_FDB_LSB];
wire [7:0] ffb = layout_reg[`CCC_FFB_MSB:`CCC_FFB_LSB];
wire [6:0] last_configured_buffer_index = layout_reg[`CCC_LCB_MSB:`CCC_LCB_LSB];
wire split_channel_mode = layout_reg[`CCC_SPLIT_BIT];
wire lock_hdr = layout_reg[`CCC_LOCK_HDR_BIT];
wire lock_tx = layout_reg[`CCC_LOCK_TX_BIT];
wire dyn_present = (fdb < `CCC_BUF_NONE);
wire fifo_present = (ffb < `CCC_BUF_NONE);
wire [7:0] lcb_ext = {1'b0, last_configured_buffer_index};
// No consistency check; odd layouts just give a zero or wrapped count
wire [7:0] fifo_count = fifo_present ? (lcb_ext - ffb + 8'h01) : 8'h00;

// Header area: four words per configured buffer
wire [8:0] ram_buf = ram_addr_reg[`CCC_RAM_AW-1:`CCC_HDR_SHIFT];
wire [8:0] hdr_limit = {1'b0, lcb_ext} + 9'h001;
wire is_hdr = (ram_buf < hdr_limit);
wire is_static_buf = ({1'b0, ram_buf} < {2'b00, fdb}) && ({1'b0, ram_buf} < {2'b00, ffb});
wire ram_locked = lock_hdr & ~in_setup & is_hdr & is_static_buf;
wire ram_wr = wr_en && (wr_addr == `CCC_OFS_RAMDATA) && ~ram_locked;
wire [31:0] ram_q;

ccc_msg_ram u_ram (
    .aclk(aclk),
    .we(ram_wr),
    .addr(ram_addr_reg),
    .wdata(merge(ram_q, wr_data, wmask)),
    .rdata(ram_q)
);

// Address decode for both channels
always @* begin
    case (wr_addr)
        `CCC_OFS_STATUS, `CCC_OFS_STARTUP, `CCC_OFS_PRTC, `CCC_OFS_TU1,
        `CCC_OFS_TU2, `CCC_OFS_TU4, `CCC_OFS_TU7, `CCC_OFS_TU8,
        `CCC_OFS_LAYOUT, `CCC_OFS_HDC, `CCC_OFS_RAMADDR, `CCC_OFS_RAMDATA,
        `CCC_OFS_LSTAT, `CCC_OFS_CSTAT: wr_hit = 1'b1;
        default: wr_hit = 1'b0;
    endcase
    case (rd_addr)
        `CCC_OFS_STATUS, `CCC_OFS_STARTUP, `CCC_OFS_PRTC, `CCC_OFS_TU1,
        `CCC_OFS_TU2, `CCC_OFS_TU4, `CCC_OFS_TU7, `CCC_OFS_TU8,
        `CCC_OFS_LAYOUT, `CCC_OFS_HDC, `CCC_OFS_RAMADDR, `CCC_OFS_RAMDATA,
        `CCC_OFS_LSTAT, `CCC_OFS_CSTAT: rd_hit = 1'b1;
        default: rd_hit = 1'b0;
    endcase
end

// Protocol state machine and coldstart inhibit
reg [5:0] pstate_next;
always @* begin
    pstate_next = pstate_reg;
    if (wr_cmd) begin
        case (cmd)
            `CCC_CMD_SETUP: pstate_next = `CCC_PST_SETUP;
            `CCC_CMD_READY: begin
                if (in_setup) begin
                    pstate_next = `CCC_PST_READY;
                end
            end
            `CCC_CMD_RUN: begin
                if (pstate_reg == `CCC_PST_READY) begin
                    pstate_next = `CCC_PST_RUN;
                end
            end
            default: pstate_next = pstate_reg;
        endcase
    end
end

wire enter_ready = (pstate_next == `CCC_PST_READY) && (pstate_reg != `CCC_PST_READY);
wire allow_cs = wr_cmd && (cmd == `CCC_CMD_ALLOW_CS);

always @(posedge aclk) begin
    if (!aresetn) begin
        pstate_reg <= `CCC_PST_DEFAULT;
        csi_reg <= 1'b0;
    end else begin
        pstate_reg <= pstate_next;
        if (enter_ready) begin
            csi_reg <= 1'b1;
        end else if (allow_cs) begin
            csi_reg <= 1'b0;
        end
    end
end

// Register writes
always @(posedge aclk) begin
    if (!aresetn) begin
        startup_ctl_reg <= `CCC_RST_ZERO;
        prtc_reg <= `CCC_RST_ZERO;
        tu1_reg <= `CCC_RST_TU1;
        tu2_reg <= `CCC_RST_ZERO;
        tu4_reg <= `CCC_RST_ZERO;
        tu7_reg <= `CCC_RST_ZERO;
        tu8_reg <= `CCC_RST_ZERO;
        layout_reg <= `CCC_RST_LAYOUT;
        hdc_reg <= `CCC_RST_ZERO;
        ram_addr_reg <= {`CCC_RAM_AW{1'b0}};
    end else begin
        if (wr_en && (wr_addr == `CCC_OFS_STARTUP)) begin
            // Command field is a strobe and never stored
            startup_ctl_reg <= merge(startup_ctl_reg, wr_data, wmask) & ~32'h0000_000f;
        end
        if (wr_en && (wr_addr == `CCC_OFS_RAMADDR)) begin
            ram_addr_reg <= wr_data[`CCC_RAM_AW-1:0];
        end
        if (cfg_wr) begin
            case (wr_addr)
                `CCC_OFS_PRTC: prtc_reg <= merge(prtc_reg, wr_data, wmask);
                `CCC_OFS_TU1: tu1_reg <= merge(tu1_reg, wr_data, wmask);
                `CCC_OFS_TU2: tu2_reg <= merge(tu2_reg, wr_data, wmask);
                `CCC_OFS_TU4: tu4_reg <= merge(tu4_reg, wr_data, wmask);
                `CCC_OFS_TU7: tu7_reg <= merge(tu7_reg, wr_data, wmask);
                `CCC_OFS_TU8: tu8_reg <= merge(tu8_reg, wr_data, wmask);
                `CCC_OFS_LAYOUT: layout_reg <= merge(layout_reg, wr_data, wmask);
                `CCC_OFS_HDC: hdc_reg <= merge(hdc_reg, wr_data, wmask);
                default: ;
            endcase
        end
    end
end

// Cycle layout: segment boundaries in macroticks
wire [15:0] mt_div = tu1_reg[`CCC_MT_DIV_MSB:0];
wire [15:0] mt_div_m1 = (mt_div == 16'h0000) ? 16'h0000 : (mt_div - 16'h0001);
wire [`CCC_MT_W-1:0] cycle_len = tu2_reg[`CCC_MT_W-1:0];
wire [`CCC_MT_W-1:0] nit_start = tu4_reg[`CCC_MT_W-1:0];
wire [9:0] slot_len = tu7_reg[`CCC_SLOT_LEN_MSB:0];
wire [9:0] slot_num = tu7_reg[`CCC_SLOT_NUM_MSB:`CCC_SLOT_NUM_LSB];
wire [5:0] mini_len = tu8_reg[`CCC_MINI_LEN_MSB:0];
wire [9:0] mini_num = tu8_reg[`CCC_SLOT_NUM_MSB:`CCC_SLOT_NUM_LSB];
wire [19:0] static_end = slot_len * slot_num;
wire [19:0] mini_span = {4'h0, mini_len} * {6'h00, mini_num};
wire [20:0] dyn_end = {1'b0, static_end} + {1'b0, mini_span};

reg [15:0] pre_cnt_reg;
reg [`CCC_MT_W-1:0] mt_cnt_reg;
wire running = (pstate_reg == `CCC_PST_RUN);
wire mt_tick = running && (pre_cnt_reg >= mt_div_m1);
wire cycle_wrap = mt_tick && ({1'b0, mt_cnt_reg} + 15'h0001 >= {1'b0, cycle_len});
wire [20:0] mt_ext = {7'h00, mt_cnt_reg};

reg [1:0] seg_next;
always @* begin
    if (mt_ext < {1'b0, static_end}) begin
        seg_next = `CCC_SEG_STATIC;
    end else if (mt_ext < dyn_end) begin
        seg_next = `CCC_SEG_DYNAMIC;
    end else if (mt_cnt_reg < nit_start) begin
        seg_next = `CCC_SEG_SYMBOL;
    end else begin
        seg_next = `CCC_SEG_NIT;
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        pre_cnt_reg <= 16'h0000;
        mt_cnt_reg <= {`CCC_MT_W{1'b0}};
    end else if (!running) begin
        pre_cnt_reg <= 16'h0000;
        mt_cnt_reg <= {`CCC_MT_W{1'b0}};
    end else if (mt_tick) begin
        pre_cnt_reg <= 16'h0000;
        mt_cnt_reg <= cycle_wrap ? {`CCC_MT_W{1'b0}} : (mt_cnt_reg + {{(`CCC_MT_W-1){1'b0}}, 1'b1});
    end else begin
        pre_cnt_reg <= pre_cnt_reg + 16'h0001;
    end
end

// Node role and registered outputs
wire startup_en = startup_ctl_reg[`CCC_STARTUP_EN_BIT];
wire sync_en = startup_ctl_reg[`CCC_SYNC_EN_BIT];
wire key_tx = startup_en | sync_en;

always @(posedge aclk) begin
    if (!aresetn) begin
        protocol_state <= `CCC_PST_DEFAULT;
        coldstart_inhibit <= 1'b0;
        startup_node_active <= 1'b0;
        sync_node_active <= 1'b0;
        coldstart_permitted <= 1'b0;
        key_buffer_mask <= 2'h0;
        static_tx_enable <= 1'b0;
        cycle_segment <= `CCC_SEG_STATIC;
        symbol_window <= 1'b0;
        cycle_start <= 1'b0;
    end else begin
        protocol_state <= pstate_reg;
        coldstart_inhibit <= csi_reg;
        startup_node_active <= startup_en;
        sync_node_active <= sync_en;
        coldstart_permitted <= running & startup_en & ~csi_reg;
        key_buffer_mask <= {key_tx & split_channel_mode, key_tx};
        static_tx_enable <= running & ~lock_tx;
        cycle_segment <= running ? seg_next : `CCC_SEG_STATIC;
        symbol_window <= running && (seg_next == `CCC_SEG_SYMBOL);
        cycle_start <= cycle_wrap;
    end
end

// Read data, latched in the cycle before the read response
reg [31:0] rd_word;
always @* begin
    case (rd_addr)
        `CCC_OFS_STATUS: rd_word = {23'h000000, csi_reg, 2'h0, pstate_reg};
        `CCC_OFS_STARTUP: rd_word = startup_ctl_reg;
        `CCC_OFS_PRTC: rd_word = prtc_reg;
        `CCC_OFS_TU1: rd_word = tu1_reg;
        `CCC_OFS_TU2: rd_word = tu2_reg;
        `CCC_OFS_TU4: rd_word = tu4_reg;
        `CCC_OFS_TU7: rd_word = tu7_reg;
        `CCC_OFS_TU8: rd_word = tu8_reg;
        `CCC_OFS_LAYOUT: rd_word = layout_reg;
        `CCC_OFS_HDC: rd_word = hdc_reg;
        `CCC_OFS_RAMADDR: rd_word = {21'h000000, ram_addr_reg};
        `CCC_OFS_RAMDATA: rd_word = ram_q;
        `CCC_OFS_LSTAT: rd_word = {20'h00000, key_tx & split_channel_mode, key_tx,
                                   fifo_present, dyn_present, fifo_count};
        `CCC_OFS_CSTAT: rd_word = {running, 13'h0000, seg_next, 2'h0, mt_cnt_reg};
        default: rd_word = `CCC_RST_ZERO;
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_rdata <= `CCC_RST_ZERO;
    end else if (rd_en) begin
        s_axi_rdata <= rd_word;
    end
end

endmodule
`default_nettype wire

// *** dv/ccc_config_sva.sv ***
// Assertion checker watching the configuration block outputs
`timescale 1ns/10ps
`default_nettype none
`include "ccc_consts.vh"
module ccc_config_sva (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [5:0] protocol_state,
    input wire logic coldstart_inhibit,
    input wire logic startup_node_active,
    input wire logic sync_node_active,
    input wire logic coldstart_permitted,
    input wire logic [1:0] key_buffer_mask,
    input wire logic static_tx_enable,
    input wire logic [1:0] cycle_segment,
    input wire logic symbol_window,
    input wire logic cycle_start
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);

    AST_RST_STATE: assert property ($rose(aresetn) |-> protocol_state == `CCC_PST_DEFAULT)
        else $error("state not default after reset");
    AST_CS_PERMIT: assert property (coldstart_permitted |-> protocol_state == `CCC_PST_RUN &&
        startup_node_active && !coldstart_inhibit)
        else $error("coldstart permitted without its conditions");
    AST_INHIBIT_SET: assert property (protocol_state == `CCC_PST_READY &&
        $past(protocol_state) == `CCC_PST_SETUP |-> coldstart_inhibit)
        else $error("inhibit not set on entering ready");
    AST_STATIC_TX: assert property (static_tx_enable |-> protocol_state == `CCC_PST_RUN)
        else $error("static transmit enabled outside run");
    AST_SEG_IDLE: assert property (protocol_state != `CCC_PST_RUN |-> cycle_segment == `CCC_SEG_STATIC)
        else $error("segment moves while not running");
    AST_SYMBOL: assert property (symbol_window == (cycle_segment == `CCC_SEG_SYMBOL))
        else $error("symbol window disagrees with segment");
    AST_KEY_MASK: assert property (key_buffer_mask[0] == (startup_node_active || sync_node_active))
        else $error("buffer 0 key role wrong");
    AST_CYC_START: assert property (cycle_start |-> protocol_state == `CCC_PST_RUN)
        else $error("cycle start outside run");
    AST_CYC_PULSE: assert property (cycle_start |=> !cycle_start)
        else $error("cycle start longer than one clock");

    cover property (coldstart_permitted);
    cover property (cycle_start);
    cover property (symbol_window);
endmodule

bind ccc_config_top ccc_config_sva chk (.*);
`default_nettype wire

// *** dv/ccc_axil_host.sv ***
// AXI4-Lite host model standing in for the configuring software
`timescale 1ns/10ps
`default_nettype none
module ccc_axil_host (
    input wire logic aclk,
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready, s_axi_araddr, s_axi_arvalid,
        s_axi_rready} = '0;

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta;
        logic tw;
        ta = 1'b0;
        tw = 1'b0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!(ta && tw)) begin
            @(posedge aclk);
            ta = ta | s_axi_awready;
            tw = tw | s_axi_wready;
            s_axi_awvalid <= s_axi_awvalid & ~s_axi_awready;
            s_axi_wvalid <= s_axi_wvalid & ~s_axi_wready;
        end
        while (!s_axi_bvalid) @(posedge aclk);
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (!s_axi_arready) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge aclk);
        s_axi_rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** dv/ccc_config_top_tb.sv ***
// Self-checking bench for the configuration block
`timescale 1ns/10ps
`default_nettype none
`include "ccc_consts.vh"
module ccc_config_top_tb;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cnt;
    logic [31:0] s_axi_wdata, s_axi_rdata, rnd, lay;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [1:0] s_axi_bresp, s_axi_rresp, key_buffer_mask, cycle_segment;
    logic [5:0] protocol_state;
    logic coldstart_inhibit, startup_node_active, sync_node_active, coldstart_permitted;
    logic static_tx_enable, symbol_window, cycle_start;
    logic [33:0] rq[$];
    logic [1:0] bq[$];
    logic [7:0] offs[8] = '{`CCC_OFS_PRTC, `CCC_OFS_TU1, `CCC_OFS_TU2, `CCC_OFS_TU4, `CCC_OFS_TU7,
        `CCC_OFS_TU8, `CCC_OFS_LAYOUT, `CCC_OFS_HDC};
    logic [31:0] rstv[8] = '{32'h0, 32'h1, 32'h0, 32'h0, 32'h0, 32'h0, `CCC_RST_LAYOUT, 32'h0};
    // First three rows are legal partitions, the fourth a deliberately bad one
    logic [7:0] fdb[4] = '{8'h80, 8'h80, 8'h06, 8'hc8};
    logic [7:0] ffb[4] = '{8'h80, 8'h02, 8'h80, 8'h05};
    logic [6:0] last_configured_buffer_index[4] = '{7'h07, 7'h03, 7'h0b, 7'h02};
    int failures = 0, cmp_count = 0, cycles = 0, i, n_sym, n_cs;
    int segn[4];

    ccc_config_top uut (.*);
    ccc_axil_host host (.*);

    task automatic chk(input logic [33:0] got, input logic [33:0] exp);
        cmp_count++;
        if (got !== exp) begin
            failures++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    task automatic wx(input logic [7:0] a, input logic [31:0] d);
        bq.push_back((a > 8'h34) ? `CCC_RESP_SLVERR : `CCC_RESP_OKAY);
        host.wr(a, d);
    endtask

    task automatic rx(input logic [7:0] a, input logic [31:0] e);
        rq.push_back({(a > 8'h34) ? `CCC_RESP_SLVERR : `CCC_RESP_OKAY, e});
        host.rd(a);
    endtask

    initial begin
        aclk = 1'b0;
        forever #10 aclk = ~aclk;
    end

    always @(posedge aclk) begin
        cycles++;
        if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) chk({s_axi_rresp, s_axi_rdata}, rq.pop_front());
        if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) chk(34'(s_axi_bresp), 34'(bq.pop_front()));
        if (cycles == 6000) begin
            failures++;
            complete_run;
        end
    end

    initial begin
        aresetn = 1'b0;
        void'($urandom(32'h51d2412c));
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        rx(`CCC_OFS_STATUS, 32'h0);
        $display("test reset done");
        for (i = 0; i < 8; i++) begin
            rnd = $urandom;
            wx(offs[i], rnd);
            rx(offs[i], rstv[i]);
        end
        wx(8'hfc, rnd);
        rx(8'hfc, 32'h0);
        $display("test protection done");
        wx(`CCC_OFS_STARTUP, 32'h1);
        rx(`CCC_OFS_STATUS, 32'h0000_000f);
        rnd = $urandom;
        wx(`CCC_OFS_HDC, rnd);
        rx(`CCC_OFS_HDC, rnd);
        s_axi_wstrb <= 4'h1;
        wx(`CCC_OFS_HDC, 32'h0);
        rx(`CCC_OFS_HDC, {rnd[31:8], 8'h00});
        s_axi_wstrb <= 4'hf;
        for (i = 0; i < 4; i++) begin
            lay = {9'h0, last_configured_buffer_index[i], ffb[i], fdb[i]};
            wx(`CCC_OFS_LAYOUT, lay);
            rx(`CCC_OFS_LAYOUT, lay);
            cnt = (ffb[i] < 8'h80) ? 8'({1'b0, last_configured_buffer_index[i]} - ffb[i] + 8'h1) : 8'h0;
            rx(`CCC_OFS_LSTAT, {22'h0, ffb[i] < 8'h80, fdb[i] < 8'h80, cnt});
        end
        wx(`CCC_OFS_RAMADDR, 32'h7ff);
        wx(`CCC_OFS_RAMDATA, rnd);
        rx(`CCC_OFS_RAMDATA, rnd);
        wx(`CCC_OFS_RAMADDR, 32'h0);
        wx(`CCC_OFS_RAMDATA, rnd);
        $display("test setup done");
        wx(`CCC_OFS_TU1, 32'h1);
        wx(`CCC_OFS_TU2, 32'd100);
        wx(`CCC_OFS_TU4, 32'd90);
        wx(`CCC_OFS_TU7, 32'h0006_0005);
        wx(`CCC_OFS_TU8, 32'h0005_0004);
        // Split mode, static headers locked, static transmit off; only buffer 0 is configured, so of the key slots only its header is locked
        wx(`CCC_OFS_LAYOUT, 32'h0d00_8080);
        wx(`CCC_OFS_STARTUP, 32'h0000_0302); // sync kept on beside startup
        rx(`CCC_OFS_STATUS, 32'h0000_0101);
        chk(34'({protocol_state, coldstart_inhibit, startup_node_active, sync_node_active, key_buffer_mask}),
            34'h3f);
        wx(`CCC_OFS_STARTUP, 32'h0000_0303);
        repeat (2) @(posedge aclk);
        chk(34'(coldstart_permitted), 34'h0);
        wx(`CCC_OFS_TU2, 32'd7);
        rx(`CCC_OFS_TU2, 32'd100);
        wx(`CCC_OFS_RAMDATA, 32'h0);
        rx(`CCC_OFS_RAMDATA, rnd);
        wx(`CCC_OFS_STARTUP, 32'h0000_0309);
        rx(`CCC_OFS_STATUS, 32'h0000_0002);
        chk(34'({coldstart_permitted, static_tx_enable}), 34'h2);
        while (cycle_start !== 1'b1) @(posedge aclk);
        n_sym = 0;
        n_cs = 0;
        segn = '{0, 0, 0, 0};
        for (i = 0; i < 100; i++) begin
            @(posedge aclk);
            segn[cycle_segment] += 1;
            n_sym += int'(symbol_window);
            n_cs += int'(cycle_start);
        end
        chk(34'({8'(segn[0]), 8'(segn[1]), 8'(segn[3]), 8'(n_cs)}), 34'h1e140a01);
        chk(34'({8'(segn[2]), 8'(n_sym)}), 34'h2828);
        $display("test run done");
        wx(`CCC_OFS_STARTUP, 32'h0000_0201);
        repeat (2) @(posedge aclk);
        chk(34'({startup_node_active, sync_node_active, key_buffer_mask, cycle_segment, static_tx_enable}),
            34'h38);
        rx(`CCC_OFS_STATUS, 32'h0000_000f);
        $display("test reconfig done");
        repeat (2) @(posedge aclk);
        complete_run;
    end
endmodule
`default_nettype wire
